/* File: hw/glc_pkg.sv */
// Package for the shared pin and status light controller.
// Assumes one 50 MHz clock and an APB slave port with 32-bit data.
package glc_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] GLC_OFF_CFG = 8'h00;
    localparam logic [7:0] GLC_OFF_DATA_DIR = 8'h04;
    localparam logic [7:0] GLC_OFF_IRQ_STS_EN = 8'h08;
    localparam logic [7:0] GLC_OFF_LED_CFG = 8'h0c;
    localparam logic [7:0] GLC_OFF_SYS_IRQ = 8'h10;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int GLC_NPIN = 6;
    localparam int GLC_CFG_BUF_LSB = 0;
    localparam int GLC_CFG_POL_LSB = 16;
    localparam int GLC_DD_DATA_LSB = 0;
    localparam int GLC_DD_DIR_LSB = 8;
    localparam int GLC_IE_STS_LSB = 0;
    localparam int GLC_IE_EN_LSB = 16;
    localparam int GLC_LC_EN_LSB = 0;
    localparam int GLC_LC_FUN_LSB = 8;
    localparam int GLC_SYS_PIN_EVT = 0;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [5:0] GLC_RST_PINS = 6'h00;
    localparam logic [1:0] GLC_RST_FUN = 2'h0;
    localparam logic [31:0] GLC_RST_WORD = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int GLC_CLK_MHZ = 50;
    localparam int GLC_TICK_US = 1000;
    localparam int GLC_STRETCH_MS = 80;
    localparam int GLC_TICK_CYCLES = GLC_TICK_US * GLC_CLK_MHZ;
    localparam int GLC_STRETCH_TICKS = GLC_STRETCH_MS * 1000 / GLC_TICK_US;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic link;
        logic spd100;
        logic full_dup;
        logic col;
        logic tx_en;
        logic rx_dv;
    } glc_port_t;

    typedef enum {
        GLC_K_LA, GLC_K_LA100, GLC_K_LA10, GLC_K_DC, GLC_K_SPD, GLC_K_TX, GLC_K_RX, GLC_K_RAW
    } glc_kind_t;

    typedef enum {GLC_S_IDLE, GLC_S_PULSE, GLC_S_GAP} glc_str_t;

endpackage : glc_pkg

/* File: hw/glc_top.sv */
// Shared pin controller: six general pins or Ethernet status lights.
// Assumes APB master on pclk, port status inputs synchronous to pclk,
// and straps stable while presetn is low and just after its release.
//
// Overview of operation
// - Six pins, each input, push-pull or open-drain output, each interrupt capable.
// - Reset clears directions, interrupt enables and interrupt polarities.
// - Output pins use push-pull or open-drain as their buffer type bit selects.
// - Open-drain: data 0 drives low, data 1 leaves pin undriven.
// - Push-pull output drives the pin to its data bit.
// - Input pin data bit reads the sampled pin level.
// - Each pin has a readable interrupt status bit and an enable bit.
// - Enabled statuses combine into one request, shown in system status.
// - Polarity set: high level sets status; clear: low level sets it.
// - Light enable makes the pin a light output, input buffer and pull-up off.
// - Light enables, function select and polarity load from straps at reset.
// - Modes 00 and 01 map link, duplex and speed lights of ports 2 and 1.
// - Mode 10 adds port 0 transmit and receive; mode 11 shows raw enables.
// - Modes 00 to 10: active drives opposite strap polarity, inactive undriven.
// - Port 0 transmit and receive pulse active 80 ms, then 81 ms gap.
// - Link/activity steady with link; activity pulses it inactive 80 ms.
// - Duplex/collision steady in full duplex, pulses on collision, off without link.
// - Speed active for 100 Mbps link, inactive for 10 Mbps or no link.
// - 100-link/activity active only on 100 Mbps link, pulsed off by activity.
// - 10-link/activity active only on 10 Mbps link, pulsed off by activity.
// - Mode 11: push-pull, pin follows raw signal regardless of polarity straps.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/10ps

module glc_top
    import glc_pkg::*;
#(
    parameter int TICK_CYCLES = GLC_TICK_CYCLES,
    parameter int STRETCH_TICKS = GLC_STRETCH_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [GLC_NPIN-1:0] pin_in,
    output logic [GLC_NPIN-1:0] pin_out,
    output logic [GLC_NPIN-1:0] pin_oe,
    output logic [GLC_NPIN-1:0] pin_ie,
    output logic [GLC_NPIN-1:0] pin_pu_en,
    input wire glc_port_t port_sts [3],
    input wire logic [GLC_NPIN-1:0] led_en_strap,
    input wire logic [1:0] led_fun_strap,
    input wire logic [GLC_NPIN-1:0] led_pol_strap,
    output logic pin_irq_req
);

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    function automatic glc_kind_t led_kind(input logic [1:0] fun, input int g);
        int k;
        k = g % 3;
        case (fun)
            2'b00: led_kind = (k == 2) ? GLC_K_LA : (k == 1) ? GLC_K_DC : GLC_K_SPD;
            2'b01: led_kind = (k == 2) ? GLC_K_LA100 : (k == 1) ? GLC_K_DC : GLC_K_LA10;
            2'b10: begin
                if (k == 2) begin
                    led_kind = (g == 5) ? GLC_K_TX : GLC_K_RX;
                end else begin
                    led_kind = (k == 1) ? GLC_K_LA : GLC_K_SPD;
                end
            end
            default: led_kind = GLC_K_RAW;
        endcase
    endfunction : led_kind

    function automatic int led_port(input logic [1:0] fun, input int g);
        if (fun[1] && (g % 3 == 2)) begin
            led_port = 0;
        end else begin
            led_port = (g >= 3) ? 2 : 1;
        end
    endfunction : led_port

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [GLC_NPIN-1:0] buf_type_q;
    logic [GLC_NPIN-1:0] irq_pol_q;
    logic [GLC_NPIN-1:0] data_q;
    logic [GLC_NPIN-1:0] dir_q;
    logic [GLC_NPIN-1:0] irq_sts_q;
    logic [GLC_NPIN-1:0] irq_en_q;
    logic [GLC_NPIN-1:0] led_en_q;
    logic [1:0] led_fun_q;
    logic [GLC_NPIN-1:0] led_pol_q;
    logic strap_done_q;
    logic [31:0] prdata_q;
    logic pin_irq_q;
    logic [GLC_NPIN-1:0] pin_out_q;
    logic [GLC_NPIN-1:0] pin_oe_q;

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    wire logic hit_cfg = (paddr == GLC_OFF_CFG);
    wire logic hit_dd = (paddr == GLC_OFF_DATA_DIR);
    wire logic hit_ie = (paddr == GLC_OFF_IRQ_STS_EN);
    wire logic hit_lc = (paddr == GLC_OFF_LED_CFG);
    wire logic hit_sys = (paddr == GLC_OFF_SYS_IRQ);
    wire logic mapped = hit_cfg | hit_dd | hit_ie | hit_lc | hit_sys;
    wire logic setup = psel & ~penable;
    wire logic wr_acc = psel & penable & pwrite & mapped;
    wire logic wr_cfg = wr_acc & hit_cfg;
    wire logic wr_dd = wr_acc & hit_dd;
    wire logic wr_ie = wr_acc & hit_ie;
    wire logic wr_lc = wr_acc & hit_lc;

    wire logic [GLC_NPIN-1:0] w_buf = pwdata[GLC_CFG_BUF_LSB +: GLC_NPIN];
    wire logic [GLC_NPIN-1:0] w_pol = pwdata[GLC_CFG_POL_LSB +: GLC_NPIN];
    wire logic [GLC_NPIN-1:0] w_data = pwdata[GLC_DD_DATA_LSB +: GLC_NPIN];
    wire logic [GLC_NPIN-1:0] w_dir = pwdata[GLC_DD_DIR_LSB +: GLC_NPIN];
    wire logic [GLC_NPIN-1:0] w_sts = pwdata[GLC_IE_STS_LSB +: GLC_NPIN];
    wire logic [GLC_NPIN-1:0] w_en = pwdata[GLC_IE_EN_LSB +: GLC_NPIN];
    wire logic [GLC_NPIN-1:0] w_len = pwdata[GLC_LC_EN_LSB +: GLC_NPIN];
    wire logic [1:0] w_fun = pwdata[GLC_LC_FUN_LSB +: 2];

    // Pin data reads the pin for inputs, the data bit for outputs
    wire logic [GLC_NPIN-1:0] rd_data = (dir_q & data_q) | (~dir_q & pin_in);
    wire logic [GLC_NPIN-1:0] irq_hit = irq_pol_q ~^ pin_in;
    wire logic irq_any = |(irq_sts_q & irq_en_q);

    logic [31:0] rd_word;
    always_comb begin
        rd_word = GLC_RST_WORD;
        if (hit_cfg) begin
            rd_word[GLC_CFG_BUF_LSB +: GLC_NPIN] = buf_type_q;
            rd_word[GLC_CFG_POL_LSB +: GLC_NPIN] = irq_pol_q;
        end
        if (hit_dd) begin
            rd_word[GLC_DD_DATA_LSB +: GLC_NPIN] = rd_data;
            rd_word[GLC_DD_DIR_LSB +: GLC_NPIN] = dir_q;
        end
        if (hit_ie) begin
            rd_word[GLC_IE_STS_LSB +: GLC_NPIN] = irq_sts_q;
            rd_word[GLC_IE_EN_LSB +: GLC_NPIN] = irq_en_q;
        end
        if (hit_lc) begin
            rd_word[GLC_LC_EN_LSB +: GLC_NPIN] = led_en_q;
            rd_word[GLC_LC_FUN_LSB +: 2] = led_fun_q;
        end
        if (hit_sys) begin
            rd_word[GLC_SYS_PIN_EVT] = pin_irq_q;
        end
    end

    assign pready = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_q;
    assign pin_irq_req = pin_irq_q;

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_type_q <= GLC_RST_PINS;
            irq_pol_q <= GLC_RST_PINS;
            data_q <= GLC_RST_PINS;
            dir_q <= GLC_RST_PINS;
            irq_en_q <= GLC_RST_PINS;
            irq_sts_q <= GLC_RST_PINS;
            prdata_q <= GLC_RST_WORD;
            pin_irq_q <= 1'b0;
        end else begin
            if (wr_cfg) begin
                buf_type_q <= w_buf;
                irq_pol_q <= w_pol;
            end
            if (wr_dd) begin
                data_q <= w_data;
                dir_q <= w_dir;
            end
            if (wr_ie) begin
                irq_en_q <= w_en;
            end
            // Level detect sets, write one clears, set wins
            irq_sts_q <= (irq_sts_q & ~(wr_ie ? w_sts : GLC_RST_PINS)) | irq_hit;
            pin_irq_q <= irq_any;
            if (setup) begin
                prdata_q <= rd_word;
            end
        end
    end

    // Light configuration taken from straps just after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_en_q <= GLC_RST_PINS;
            led_fun_q <= GLC_RST_FUN;
            led_pol_q <= GLC_RST_PINS;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            led_en_q <= led_en_strap;
            led_fun_q <= led_fun_strap;
            led_pol_q <= led_pol_strap;
            strap_done_q <= 1'b1;
        end else if (wr_lc) begin
            led_en_q <= w_len;
            led_fun_q <= w_fun;
        end
    end

    // ---------------------------------------------------------------
    // Prescaler
    // ---------------------------------------------------------------
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
    localparam int SW = $clog2(STRETCH_TICKS + 2);
    localparam logic [SW-1:0] PULSE_LEN = SW'(STRETCH_TICKS);
    localparam logic [SW-1:0] GAP_LEN = SW'(STRETCH_TICKS + 1);

    logic [PW-1:0] pre_q;
    wire logic tick = (pre_q == PRE_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else begin
            pre_q <= tick ? '0 : pre_q + PW'(1);
        end
    end

    // ---------------------------------------------------------------
    // Per-light event selection and stretchers
    // ---------------------------------------------------------------
    glc_kind_t kind [GLC_NPIN];
    glc_port_t ps [GLC_NPIN];
    logic [GLC_NPIN-1:0] evt;
    logic [GLC_NPIN-1:0] pulse;
    logic [GLC_NPIN-1:0] led_act;
    logic [GLC_NPIN-1:0] raw;

    always_comb begin
        for (int g = 0; g < GLC_NPIN; g++) begin
            kind[g] = led_kind(led_fun_q, g);
            ps[g] = port_sts[led_port(led_fun_q, g)];
            raw[g] = (g == 5 || g % 3 == 1) ? ps[g].tx_en : ps[g].rx_dv;
            case (kind[g])
                GLC_K_LA, GLC_K_LA100, GLC_K_LA10: evt[g] = ps[g].tx_en | ps[g].rx_dv;
                GLC_K_DC: evt[g] = ps[g].col & ps[g].link & ~ps[g].full_dup;
                GLC_K_TX: evt[g] = ps[g].tx_en;
                GLC_K_RX: evt[g] = ps[g].rx_dv;
                default: evt[g] = 1'b0;
            endcase
            case (kind[g])
                GLC_K_LA: led_act[g] = ps[g].link & ~pulse[g];
                GLC_K_LA100: led_act[g] = ps[g].link & ps[g].spd100 & ~pulse[g];
                GLC_K_LA10: led_act[g] = ps[g].link & ~ps[g].spd100 & ~pulse[g];
                GLC_K_DC: led_act[g] = ps[g].link & (ps[g].full_dup | pulse[g]);
                GLC_K_SPD: led_act[g] = ps[g].link & ps[g].spd100;
                GLC_K_TX, GLC_K_RX: led_act[g] = pulse[g];
                default: led_act[g] = raw[g];
            endcase
        end
    end

    for (genvar g = 0; g < GLC_NPIN; g++) begin : g_str
        glc_str_t st_q;
        logic [SW-1:0] cnt_q;
        assign pulse[g] = (st_q == GLC_S_PULSE);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st_q <= GLC_S_IDLE;
                cnt_q <= '0;
            end else begin
                case (st_q)
                    GLC_S_IDLE: begin
                        if (evt[g]) begin
                            st_q <= GLC_S_PULSE;
                            cnt_q <= PULSE_LEN;
                        end
                    end
                    GLC_S_PULSE: begin
                        if (tick && cnt_q == SW'(1)) begin
                            st_q <= GLC_S_GAP;
                            cnt_q <= GAP_LEN;
                        end else if (tick) begin
                            cnt_q <= cnt_q - SW'(1);
                        end
                    end
                    GLC_S_GAP: begin
                        if (tick && cnt_q == SW'(1)) begin
                            st_q <= GLC_S_IDLE;
                        end else if (tick) begin
                            cnt_q <= cnt_q - SW'(1);
                        end
                    end
                    default: st_q <= GLC_S_IDLE;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    logic [GLC_NPIN-1:0] out_d;
    logic [GLC_NPIN-1:0] oe_d;

    always_comb begin
        for (int g = 0; g < GLC_NPIN; g++) begin
            if (led_en_q[g] && led_fun_q == 2'b11) begin
                out_d[g] = led_act[g];
                oe_d[g] = 1'b1;
            end else if (led_en_q[g]) begin
                out_d[g] = ~led_pol_q[g];
                oe_d[g] = led_act[g];
            end else if (dir_q[g] && buf_type_q[g]) begin
                out_d[g] = data_q[g];
                oe_d[g] = 1'b1;
            end else if (dir_q[g]) begin
                out_d[g] = 1'b0;
                oe_d[g] = ~data_q[g];
            end else begin
                out_d[g] = 1'b0;
                oe_d[g] = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_q <= GLC_RST_PINS;
            pin_oe_q <= GLC_RST_PINS;
        end else begin
            pin_out_q <= out_d;
            pin_oe_q <= oe_d;
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;
    assign pin_ie = ~led_en_q;
    assign pin_pu_en = ~led_en_q;

endmodule : glc_top

/* File: test/glc_far_side.sv */
// Far-side model of the six shared pins.
// Assumes a pull-up on every pin and an optional external driver.
`timescale 1ns/10ps
module glc_far_side
    import glc_pkg::*;
(
    input wire logic [GLC_NPIN-1:0] pin_out,
    input wire logic [GLC_NPIN-1:0] pin_oe,
    input wire logic [GLC_NPIN-1:0] ext_oe,
    input wire logic [GLC_NPIN-1:0] ext_val,
    output logic [GLC_NPIN-1:0] pin_in
);
    // ---------------------------------------------
    // Wire level, pull-up when nobody drives
    // ---------------------------------------------
    logic [GLC_NPIN-1:0] ext_lvl;
    assign ext_lvl = (ext_oe & ext_val) | ~ext_oe;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : glc_far_side

/* File: test/glc_asserts.sv */
// Port checker for glc_top.
// Assumes binding to every glc_top instance.
`timescale 1ns/10ps
module glc_asserts
    import glc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [GLC_NPIN-1:0] pin_out,
    input wire logic [GLC_NPIN-1:0] pin_oe,
    input wire logic [GLC_NPIN-1:0] pin_ie,
    input wire logic [GLC_NPIN-1:0] pin_pu_en,
    input wire logic pin_irq_req
);
    // ---------------------------------------------
    // Helpers and assertions
    // ---------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr_q;
    assign acc = psel && penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= acc && pwrite;
        end
    end
    a_pready_now: assert property (acc |-> pready)
        else $error("pready low in access");
    a_unmapped_err: assert property (acc && paddr > GLC_OFF_SYS_IRQ |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && paddr <= GLC_OFF_SYS_IRQ && paddr[1:0] == 0 |-> !pslverr)
        else $error("mapped access refused");
    a_err_quiet: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access");
    a_sys_event: assert property (acc && !pwrite && paddr == GLC_OFF_SYS_IRQ
        |-> prdata == {31'h0, $past(pin_irq_req)})
        else $error("system status bit wrong");
    a_ie_pullup: assert property (pin_ie == pin_pu_en)
        else $error("input buffer and pull-up disagree");
    a_reset_inputs: assert property ($rose(presetn)
        |-> (pin_ie == 6'h3f && pin_oe == 6'h00) ##1 pin_oe == 6'h00)
        else $error("pin driven after reset");
    a_drive_stable: assert property (pin_ie == 6'h3f && $past(pin_ie) == 6'h3f
        && $past(pin_ie, 2) == 6'h3f && !wr_q && !$past(wr_q)
        |-> $stable(pin_oe) && $stable(pin_out))
        else $error("pin drive changed without write");
    a_irq_mask: assert property (acc && pwrite && paddr == GLC_OFF_IRQ_STS_EN
        && pwdata[21:16] == 6'h00 |-> ##[1:2] !pin_irq_req)
        else $error("request with all enables clear");
    c_refused: cover property (acc && pslverr);
    c_irq: cover property (pin_irq_req);
    c_lights: cover property (pin_ie == 6'h00);
endmodule : glc_asserts

bind glc_top glc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_ie(pin_ie), .pin_pu_en(pin_pu_en), .pin_irq_req(pin_irq_req));

/* File: test/tb.sv */
// Testbench for glc_top.
// Assumes short prescaler and stretch counts for simulation.
`timescale 1ns/10ps
module tb
    import glc_pkg::*;
;
    // ---------------------------------------------
    // Signals and instances
    // ---------------------------------------------
    localparam int TK = 4;
    localparam int ST = 3;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_irq_req, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] pin_in, pin_out, pin_oe, pin_ie, pin_pu_en, ext_oe, ext_val;
    logic [5:0] led_en_strap, led_pol_strap;
    logic [1:0] led_fun_strap;
    glc_port_t port_sts [3];
    int n_errors, tests_run, len;
    glc_top #(.TICK_CYCLES(TK), .STRETCH_TICKS(ST)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_ie(pin_ie), .pin_pu_en(pin_pu_en),
        .port_sts(port_sts), .led_en_strap(led_en_strap), .led_fun_strap(led_fun_strap),
        .led_pol_strap(led_pol_strap), .pin_irq_req(pin_irq_req));
    glc_far_side u_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_oe(ext_oe),
        .ext_val(ext_val), .pin_in(pin_in));
    always #10 pclk = ~pclk;
    // ---------------------------------------------
    // Tasks
    // ---------------------------------------------
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask : rdc
    task wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt
    task do_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : do_reset
    task pulse(input int b, input logic lvl, input string n);
        int i;
        i = 0;
        while (pin_oe[b] !== lvl && i < 40) begin
            @(posedge pclk);
            i++;
        end
        len = 0;
        while (pin_oe[b] === lvl && len < 100) begin
            @(posedge pclk);
            len++;
        end
        if (i >= 40 || len >= 100) begin
            n_errors++;
            stop_test();
        end
        chk(n, 32'(len >= (ST - 1) * TK && len <= ST * TK + 1), 32'h1);
    endtask : pulse
    // ---------------------------------------------
    // Sequence
    // ---------------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        ext_oe = 0; ext_val = 0; led_en_strap = 0; led_fun_strap = 0; led_pol_strap = 0;
        port_sts = '{default: '0}; n_errors = 0; tests_run = 0;
        do_reset();
        rdc("cfg", GLC_OFF_CFG, 32'h0);
        rdc("irq", GLC_OFF_IRQ_STS_EN, 32'h0);
        rdc("dd", GLC_OFF_DATA_DIR, 32'h3f);
        rdc("led", GLC_OFF_LED_CFG, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("bad_err", 32'(err), 32'h1);
        chk("bad_rd", rd, 32'h0);
        apb(1'b1, GLC_OFF_CFG, 32'h3f);
        apb(1'b1, GLC_OFF_DATA_DIR, 32'h3f2a);
        wt(2);
        chk("pp_oe", 32'(pin_oe), 32'h3f);
        chk("pp_out", 32'(pin_out), 32'h2a);
        rdc("pp_rd", GLC_OFF_DATA_DIR, 32'h3f2a);
        apb(1'b1, GLC_OFF_CFG, 32'h0);
        apb(1'b1, GLC_OFF_DATA_DIR, 32'h3f0f);
        wt(2);
        chk("od_oe", 32'(pin_oe), 32'h30);
        chk("od_out", 32'(pin_out & pin_oe), 32'h0);
        apb(1'b1, GLC_OFF_DATA_DIR, 32'h0);
        @(posedge pclk);
        ext_oe <= 6'h3f;
        ext_val <= 6'h15;
        rdc("in_rd", GLC_OFF_DATA_DIR, 32'h15);
        apb(1'b1, GLC_OFF_IRQ_STS_EN, 32'h3f);
        rdc("sts_lo", GLC_OFF_IRQ_STS_EN, 32'h2a);
        chk("req_off", 32'(pin_irq_req), 32'h0);
        apb(1'b1, GLC_OFF_CFG, 32'h1_0000);
        apb(1'b1, GLC_OFF_IRQ_STS_EN, 32'h1_003f);
        wt(3);
        rdc("sts_hi", GLC_OFF_IRQ_STS_EN, 32'h1_002b);
        chk("req_on", 32'(pin_irq_req), 32'h1);
        rdc("sys_on", GLC_OFF_SYS_IRQ, 32'h1);
        apb(1'b1, GLC_OFF_CFG, 32'h3f_0000);
        @(posedge pclk);
        ext_val <= 6'h00;
        apb(1'b1, GLC_OFF_IRQ_STS_EN, 32'h3f);
        wt(3);
        rdc("sts_clr", GLC_OFF_IRQ_STS_EN, 32'h0);
        rdc("sys_off", GLC_OFF_SYS_IRQ, 32'h0);
        @(posedge pclk);
        ext_oe <= 6'h00;
        port_sts[1] <= glc_port_t'(6'b110000);
        port_sts[2] <= glc_port_t'(6'b101000);
        apb(1'b1, GLC_OFF_LED_CFG, 32'h3f);
        wt(3);
        chk("ie", 32'(pin_ie | pin_pu_en), 32'h0);
        chk("m0_oe", 32'(pin_oe), 32'h35);
        chk("m0_out", 32'(pin_out & pin_oe), 32'h35);
        apb(1'b1, GLC_OFF_LED_CFG, 32'h13f);
        wt(3);
        chk("m1_oe", 32'(pin_oe), 32'h1c);
        @(posedge pclk);
        port_sts[0] <= glc_port_t'(6'b000010);
        port_sts[1] <= glc_port_t'(6'b110001);
        port_sts[2] <= glc_port_t'(6'b101010);
        apb(1'b1, GLC_OFF_LED_CFG, 32'h33f);
        wt(3);
        chk("m3_oe", 32'(pin_oe), 32'h3f);
        chk("m3_out", 32'(pin_out), 32'h31);
        @(posedge pclk);
        port_sts[0] <= glc_port_t'(6'b000000);
        port_sts[1] <= glc_port_t'(6'b110000);
        port_sts[2] <= glc_port_t'(6'b101000);
        led_en_strap <= 6'h3f;
        led_fun_strap <= 2'h2;
        led_pol_strap <= 6'h3f;
        do_reset();
        rdc("strap", GLC_OFF_LED_CFG, 32'h23f);
        wt(6);
        chk("m2_oe", 32'(pin_oe), 32'h13);
        chk("m2_out", 32'(pin_out & pin_oe), 32'h0);
        @(posedge pclk);
        port_sts[0].tx_en <= 1'b1;
        @(posedge pclk);
        port_sts[0].tx_en <= 1'b0;
        pulse(5, 1'b1, "tx_pulse");
        port_sts[0].tx_en <= 1'b1;
        @(posedge pclk);
        port_sts[0].tx_en <= 1'b0;
        wt(8);
        chk("tx_gap", 32'(pin_oe[5]), 32'h0);
        @(posedge pclk);
        port_sts[1].rx_dv <= 1'b1;
        @(posedge pclk);
        port_sts[1].rx_dv <= 1'b0;
        pulse(1, 1'b0, "la_pulse");
        stop_test();
    end
endmodule : tb
